// *** fault_prot_params.svh ***
// Constants of the amplifier fault protection and diagnostic block.
`ifndef FAULT_PROT_PARAMS_SVH
`define FAULT_PROT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ            64'd250000000
`define SHORT_OFF_S       64'd7
`define LONG_OFF_S        64'd9
`define RETRY_WINDOW_H    64'd24
`define SHORT_OFF_CYC     (`SHORT_OFF_S * `CLK_HZ)
`define LONG_OFF_CYC      (`LONG_OFF_S * `CLK_HZ)
`define RETRY_WINDOW_CYC  (`RETRY_WINDOW_H * 64'd3600 * `CLK_HZ)
`define STABLE_S          64'd1
`define STABLE_CYC        (`STABLE_S * `CLK_HZ)

// ----------------------------------------------------------------------------
// Escalation thresholds
// ----------------------------------------------------------------------------
`define OC_ESCALATE       4'd9
`define RS_ESCALATE       4'd2

// ----------------------------------------------------------------------------
// Display codes, two ASCII characters, first character in the high byte
// ----------------------------------------------------------------------------
`define CODE_LINK_FAIL    16'h4130
`define CODE_OVERCURRENT  16'h4131
`define CODE_REG_SHORT    16'h4132
`define CODE_STANDBY      16'h4139
`define CODE_NORMAL       16'h4141
`define CODE_STBY_CHAR    16'h2053
`define CODE_OPER_CHAR    16'h2050
`define CODE_BLANK        16'h2020

// ----------------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------------
`define REG_CTRL          4'h0
`define REG_STATUS        4'h1
`define REG_IRQ_STAT      4'h2
`define REG_IRQ_MASK      4'h3
`define REG_COUNTS        4'h4
`define CTRL_FATAL_BIT    0
`define CTRL_NORESET_BIT  1
`define IRQ_MASK_RST      8'h00

`endif

// *** fault_prot_pkg.sv ***
// Types of the amplifier fault protection and diagnostic block.
package fault_prot_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // Selector positions of the front panel meter.
    typedef enum logic [2:0]
    {
        sel_forward_power,
        sel_reflected_power,
        sel_current,
        sel_voltage,
        sel_input_level,
        sel_temperature
    } selector_t;

    // Protection sequencer states.
    typedef enum logic [2:0]
    {
        st_run,
        st_off_short,
        st_off_long,
        st_locked
    } prot_state_t;

    // Fault class that caused the last shutdown.
    typedef enum logic [1:0]
    {
        cause_none,
        cause_oc,
        cause_rs
    } cause_t;

endpackage

// *** down_timer.sv ***
// Loadable down counter giving one done pulse when it reaches zero.
module down_timer
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        load,
    input  wire logic [63:0] value,
    output logic             busy,
    output logic             done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [63:0] count_reg;

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------

    // Load wins over counting so a restart never merges with the old run.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_reg <= 64'h0;
            busy      <= 1'b0;
            done      <= 1'b0;
        end
        else if (load)
        begin
            count_reg <= value;
            busy      <= 1'b1;
            done      <= 1'b0;
        end
        else
        begin
            done <= busy && (count_reg <= 64'h1);
            if (count_reg > 64'h1)
                count_reg <= count_reg - 64'h1;
            else
            begin
                count_reg <= 64'h0;
                busy      <= 1'b0;
            end
        end
    end

endmodule

// *** fault_prot.sv ***
// Fault protection, retry sequencing and front panel diagnostic display.
//
// The register addresses and the strobed register port were left to the implementer.
`include "fault_prot_params.svh"
// Functional notes
// - Selector at supply voltage shows a two character status code.
// - Error code goes away once operation is normal again.
// - Error code stays while its fault persists.
// - Link failure shows A0 and holds the amplifier off.
// - Overcurrent shows A1 and lights current and voltage lamps.
// - Each overcurrent event: off seven seconds, then retry.
// - Ninth consecutive overcurrent: off nine seconds, clear count, retry.
// - A single isolated fault needs no further protective action.
// - Regulator short shows A2.
// - Each regulator short: off seven seconds, then retry.
// - Second consecutive short: off nine seconds, clear count, retry.
// - Regulator short lights lock and voltage lamps.
// - Forward power position shows S in standby, P when operating.
// - Retries continue up to 24 hours unless non-resettable.
// - Reset button clears history unless the fault is fatal.
module fault_prot
#(
    parameter logic [63:0] SHORT_OFF_CYC    = `SHORT_OFF_CYC,
    parameter logic [63:0] LONG_OFF_CYC     = `LONG_OFF_CYC,
    parameter logic [63:0] RETRY_WINDOW_CYC = `RETRY_WINDOW_CYC,
    parameter logic [63:0] STABLE_CYC       = `STABLE_CYC
)
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        link_fail,
    input  wire logic        overcurrent,
    input  wire logic        reg_short,
    input  wire logic        standby_sw,
    input  wire logic        reset_button,
    input  wire logic [2:0]  selector,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    output logic             amp_enable,
    output logic [15:0]      display_code,
    output logic             lock_led,
    output logic             current_led,
    output logic             voltage_led,
    output logic             irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    fault_prot_pkg::prot_state_t state_reg;
    fault_prot_pkg::prot_state_t state_next;
    fault_prot_pkg::cause_t      cause_reg;
    logic [3:0]  oc_count_reg;
    logic [3:0]  rs_count_reg;
    logic [1:0]  ctrl_reg;
    logic [7:0]  irq_stat_reg;
    logic [7:0]  irq_mask_reg;
    logic        oc_prev_reg;
    logic        rs_prev_reg;
    logic        cur_hist_reg;
    logic        volt_hist_reg;
    logic [63:0] window_reg;
    logic        window_expired;
    logic        timer_load;
    logic [63:0] timer_value;
    logic        timer_busy;
    logic        timer_done;
    logic        stab_load;
    logic        stab_busy;
    logic        stab_done;
    logic        oc_event;
    logic        rs_event;
    logic        fault_event;
    logic        oc_escalate;
    logic        rs_escalate;
    logic        clear_hist;
    logic        running;
    logic [15:0] code_next;
    logic [7:0]  irq_events;
    logic [7:0]  status_bits;
    logic [31:0] rdata_next;

    // Saturating increment shared by both consecutive counters.
    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == 4'hf) ? v : v + 4'h1;
    endfunction

    // ------------------------------------------------------------------------
    // Event decoding
    // ------------------------------------------------------------------------

    // Rising edges only, so a fault held high counts once per occurrence.
    assign running     = (state_reg == fault_prot_pkg::st_run);
    assign oc_event    = running && overcurrent && !oc_prev_reg && !link_fail;
    assign rs_event    = running && reg_short && !rs_prev_reg && !link_fail
                         && !oc_event;
    assign fault_event = oc_event || rs_event;
    assign oc_escalate = oc_event && (sat_inc(oc_count_reg) >= `OC_ESCALATE);
    assign rs_escalate = rs_event && (sat_inc(rs_count_reg) >= `RS_ESCALATE);
    assign window_expired = (window_reg >= RETRY_WINDOW_CYC);
    // Fatal faults ignore the button so the cause cannot be masked.
    assign clear_hist  = reset_button && !ctrl_reg[`CTRL_FATAL_BIT];

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------

    // One shutdown timer serves both the seven and nine second waits.
    assign timer_load  = fault_event;
    assign timer_value = (oc_escalate || rs_escalate) ? LONG_OFF_CYC
                                                       : SHORT_OFF_CYC;
    assign stab_load   = (state_reg != fault_prot_pkg::st_run)
                         && (state_next == fault_prot_pkg::st_run);

    down_timer off_timer
    (
        .clk   (clk),
        .srst  (srst),
        .load  (timer_load),
        .value (timer_value),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // Restart is counted clean once it has run fault free for a while.
    down_timer stable_timer
    (
        .clk   (clk),
        .srst  (srst),
        .load  (stab_load),
        .value (STABLE_CYC),
        .busy  (stab_busy),
        .done  (stab_done)
    );

    // ------------------------------------------------------------------------
    // Protection sequencer
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            fault_prot_pkg::st_run:
            begin
                if (oc_escalate || rs_escalate)
                    state_next = fault_prot_pkg::st_off_long;
                else if (fault_event)
                    state_next = fault_prot_pkg::st_off_short;
            end
            fault_prot_pkg::st_off_short,
            fault_prot_pkg::st_off_long:
            begin
                // Retries stop once the day is used up or retry is barred.
                if (ctrl_reg[`CTRL_NORESET_BIT] || window_expired)
                    state_next = fault_prot_pkg::st_locked;
                else if (timer_done)
                    state_next = fault_prot_pkg::st_run;
            end
            fault_prot_pkg::st_locked:
            begin
                if (clear_hist)
                    state_next = fault_prot_pkg::st_run;
            end
            default:
                state_next = fault_prot_pkg::st_run;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_reg <= fault_prot_pkg::st_run;
        else
            state_reg <= state_next;
    end

    // Retry window counts time spent shut down since the history was cleared.
    always_ff @(posedge clk)
    begin
        if (srst || clear_hist)
            window_reg <= 64'h0;
        else if (!running && !window_expired)
            window_reg <= window_reg + 64'h1;
    end

    // ------------------------------------------------------------------------
    // Consecutive event counters and history
    // ------------------------------------------------------------------------

    // A single event only starts a count; nothing escalates from it.
    // An event in the cycle of a button press still counts: set wins.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            oc_count_reg  <= 4'h0;
            rs_count_reg  <= 4'h0;
            cause_reg     <= fault_prot_pkg::cause_none;
            cur_hist_reg  <= 1'b0;
            volt_hist_reg <= 1'b0;
        end
        else
        begin
            if (oc_escalate)
                oc_count_reg <= 4'h0;
            else if (oc_event)
                oc_count_reg <= sat_inc(clear_hist ? 4'h0
                                                   : oc_count_reg);
            else if (clear_hist || (stab_done && running))
                oc_count_reg <= 4'h0;
            if (rs_escalate)
                rs_count_reg <= 4'h0;
            else if (rs_event)
                rs_count_reg <= sat_inc(clear_hist ? 4'h0
                                                   : rs_count_reg);
            else if (clear_hist || (stab_done && running))
                rs_count_reg <= 4'h0;
            if (oc_event)
                cause_reg <= fault_prot_pkg::cause_oc;
            else if (rs_event)
                cause_reg <= fault_prot_pkg::cause_rs;
            else if (clear_hist || (stab_done && running))
                cause_reg <= fault_prot_pkg::cause_none;
            cur_hist_reg  <= (cur_hist_reg && !clear_hist) || oc_event;
            volt_hist_reg <= (volt_hist_reg && !clear_hist) || fault_event;
        end
        oc_prev_reg <= !srst && overcurrent;
        rs_prev_reg <= !srst && reg_short;
    end

    // ------------------------------------------------------------------------
    // Display code selection
    // ------------------------------------------------------------------------
    always_comb
    begin
        code_next = `CODE_BLANK;
        if (selector == fault_prot_pkg::sel_forward_power)
            code_next = (standby_sw || !running) ? `CODE_STBY_CHAR
                                                 : `CODE_OPER_CHAR;
        else if (selector == fault_prot_pkg::sel_voltage)
        begin
            if (link_fail)
                code_next = `CODE_LINK_FAIL;
            else if (cause_reg == fault_prot_pkg::cause_oc || overcurrent)
                code_next = `CODE_OVERCURRENT;
            else if (cause_reg == fault_prot_pkg::cause_rs || reg_short)
                code_next = `CODE_REG_SHORT;
            else if (standby_sw)
                code_next = `CODE_STANDBY;
            else
                code_next = `CODE_NORMAL;
        end
    end

    // ------------------------------------------------------------------------
    // Panel outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            amp_enable   <= 1'b0;
            display_code <= `CODE_BLANK;
            lock_led     <= 1'b0;
            current_led  <= 1'b0;
            voltage_led  <= 1'b0;
        end
        else
        begin
            amp_enable   <= running && !link_fail && !standby_sw
                            && !fault_event;
            display_code <= code_next;
            lock_led     <= !running || link_fail || reg_short;
            current_led  <= cur_hist_reg || overcurrent;
            voltage_led  <= volt_hist_reg || overcurrent || reg_short;
        end
    end

    // ------------------------------------------------------------------------
    // Register port and interrupts
    // ------------------------------------------------------------------------
    assign irq_events  = {4'h0, link_fail, oc_escalate || rs_escalate,
                          rs_event, oc_event};
    assign status_bits = {3'h0, timer_busy, link_fail, state_reg};
    assign rdata_next  =
        (addr == `REG_CTRL)     ? {30'h0, ctrl_reg} :
        (addr == `REG_STATUS)   ? {24'h0, status_bits} :
        (addr == `REG_IRQ_STAT) ? {24'h0, irq_stat_reg} :
        (addr == `REG_IRQ_MASK) ? {24'h0, irq_mask_reg} :
        (addr == `REG_COUNTS)   ? {24'h0, rs_count_reg, oc_count_reg} :
                                  32'h0;

    // Event set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_reg     <= 2'h0;
            irq_stat_reg <= 8'h00;
            irq_mask_reg <= `IRQ_MASK_RST;
            rdata        <= 32'h0;
            irq          <= 1'b0;
        end
        else
        begin
            if (wr && addr == `REG_CTRL)
                ctrl_reg <= wdata[1:0];
            if (wr && addr == `REG_IRQ_MASK)
                irq_mask_reg <= wdata[7:0];
            irq_stat_reg <= (irq_stat_reg & ~((wr && addr == `REG_IRQ_STAT)
                            ? wdata[7:0] : 8'h00)) | irq_events;
            rdata <= rd ? rdata_next : 32'h0;
            irq   <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule

// *** fault_prot_properties.sv ***
// Port level checker for the fault protection block.
module fault_prot_checker
#(
    parameter logic [63:0] SHORT_OFF_CYC = 64'd50
)
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        link_fail,
    input wire logic        overcurrent,
    input wire logic        reg_short,
    input wire logic        standby_sw,
    input wire logic [2:0]  selector,
    input wire logic        amp_enable,
    input wire logic [15:0] display_code,
    input wire logic        lock_led,
    input wire logic        current_led,
    input wire logic        voltage_led
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Fault events and restart timing
    // ----------------------------------------
    // Restarts later than this count as a hang rather than a long off time.
    localparam int RESTART_MAX = 400;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic [63:0] off_cnt;
    logic        armed;

    sequence oc_ev;
        $rose(overcurrent) && amp_enable && !link_fail;
    endsequence
    sequence rs_ev;
        $rose(reg_short) && !overcurrent && amp_enable && !link_fail;
    endsequence

    // Off time is counted whenever the amplifier is off but judged only after a fault, so standby is not judged.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            off_cnt <= 64'h0;
            armed   <= 1'b0;
        end
        else
        begin
            off_cnt <= amp_enable ? 64'h0 : off_cnt + 64'h1;
            if ($rose(overcurrent) || $rose(reg_short))
                armed <= amp_enable;
            else if (amp_enable)
                armed <= 1'b0;
        end
    end

    a_link_off: assert property (link_fail |=> !amp_enable)
        else $error("amplifier running during link failure");
    a_link_code: assert property (link_fail && selector == 3'h3
        |=> display_code == 16'h4130)
        else $error("link failure code missing");
    a_oc_lamps: assert property (oc_ev
        |=> !amp_enable && current_led && voltage_led)
        else $error("overcurrent response wrong");
    a_oc_code: assert property (oc_ev and selector == 3'h3
        |=> display_code == 16'h4131)
        else $error("overcurrent code missing");
    a_rs_lamps: assert property (rs_ev |=> lock_led && voltage_led)
        else $error("regulator short lamps wrong");
    // An older overcurrent cause may still show for one cycle, so the
    // regulator code is judged once its own cause has been latched.
    a_rs_code: assert property ((rs_ev and selector == 3'h3)
        ##1 (selector == 3'h3 && !overcurrent && !link_fail)
        |=> display_code == 16'h4132)
        else $error("regulator short code missing");
    a_off_span: assert property (armed && $rose(amp_enable)
        |-> off_cnt >= SHORT_OFF_CYC)
        else $error("shutdown too short");
    a_retry_bound: assert property (oc_ev or rs_ev
        |-> ##[1:RESTART_MAX] amp_enable)
        else $error("no restart after fault");
    a_fwd_standby: assert property (selector == 3'h0 && standby_sw
        |=> display_code == 16'h2053)
        else $error("standby letter missing");
endmodule

bind fault_prot fault_prot_checker #(.SHORT_OFF_CYC(SHORT_OFF_CYC)) chk_i
(
    .clk          (clk),
    .srst         (srst),
    .link_fail    (link_fail),
    .overcurrent  (overcurrent),
    .reg_short    (reg_short),
    .standby_sw   (standby_sw),
    .selector     (selector),
    .amp_enable   (amp_enable),
    .display_code (display_code),
    .lock_led     (lock_led),
    .current_led  (current_led),
    .voltage_led  (voltage_led)
);

// *** front_panel.sv ***
// Operator side of the front panel: selector, standby switch, reset button.
module front_panel
(
    input  wire logic  clk,
    output logic [2:0] selector,
    output logic       standby_sw,
    output logic       reset_button
);
    timeunit 1ns;
    timeprecision 1ps;
    // Panel starts at the supply voltage position with the unit switched on.
    initial
    begin
        selector     = 3'h3;
        standby_sw   = 1'b0;
        reset_button = 1'b0;
    end
    // Controls change just after an edge, like a debounced switch.
    task automatic turn(input logic [2:0] s);
        @(posedge clk) selector <= s;
    endtask
    task automatic stand(input logic b);
        @(posedge clk) standby_sw <= b;
    endtask
    task automatic press;
        @(posedge clk) reset_button <= 1'b1;
        @(posedge clk) reset_button <= 1'b0;
    endtask
endmodule

// *** fault_prot_bench.sv ***
// Self-checking bench for the fault protection block.
module fault_prot_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    // Short counts keep the run brief; expectations follow from them.
    localparam logic [63:0] SHORT  = 64'd50;
    localparam logic [63:0] LONG   = 64'd80;
    localparam logic [63:0] STABLE = 64'd20;
    logic        clk = 1'b0, srst = 1'b1;
    logic        link_fail = 1'b0, overcurrent = 1'b0, reg_short = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        wr = 1'b0, rd = 1'b0;
    logic        amp_enable, lock_led, current_led, voltage_led, irq;
    logic [15:0] display_code;
    wire  [2:0]  selector;
    wire         standby_sw, reset_button;
    int          error_cnt = 0, n_tests = 0;

    fault_prot #(.SHORT_OFF_CYC(SHORT), .LONG_OFF_CYC(LONG),
        .RETRY_WINDOW_CYC(64'd5000), .STABLE_CYC(STABLE)) dut
    (.clk(clk), .srst(srst), .link_fail(link_fail),
     .overcurrent(overcurrent), .reg_short(reg_short),
     .standby_sw(standby_sw), .reset_button(reset_button),
     .selector(selector), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
     .rdata(rdata), .amp_enable(amp_enable), .display_code(display_code),
     .lock_led(lock_led), .current_led(current_led),
     .voltage_led(voltage_led), .irq(irq));
    front_panel panel
    (.clk(clk), .selector(selector), .standby_sw(standby_sw),
     .reset_button(reset_button));

    // Free running 250 MHz clock.
    initial
    begin
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One cycle fault pulse: 0 overcurrent, 1 regulator short.
    task automatic pulse(input bit rs);
        @(posedge clk);
        if (rs)
            reg_short <= 1'b1;
        else
            overcurrent <= 1'b1;
        @(posedge clk);
        reg_short   <= 1'b0;
        overcurrent <= 1'b0;
        #1;
    endtask
    // Counts edges until the amplifier runs; bounded so a hang ends.
    task automatic wait_on(inout int n);
        while (!amp_enable && n < 1000)
        begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // Off time must match the expected count within the restart slack.
    task automatic off_chk(input int n, input logic [63:0] e);
        chk(32'(n >= int'(e) && n <= int'(e) + 4), 32'h1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        tick(2);
        chk(display_code, 16'h4141);
        rd_reg(4'h3, d);
        chk(d, 32'h0);
        wr_reg(4'h3, 32'h5);
        rd_reg(4'h3, d);
        chk(d, 32'h5);
        rd_reg(4'hf, d);
        chk(d, 32'h0);
        wr_reg(4'h3, 32'h1);
    endtask
    task automatic t_oc_single;
        logic [31:0] d;
        int n = 22;
        pulse(1'b0);
        chk(amp_enable, 1'b0);
        chk({current_led, voltage_led}, 2'b11);
        chk(display_code, 16'h4131);
        tick(2);
        chk(irq, 1'b1);
        tick(20);
        chk(display_code, 16'h4131);
        wait_on(n);
        off_chk(n, SHORT);
        rd_reg(4'h4, d);
        chk(d[3:0], 4'h1);
        wr_reg(4'h2, 32'h1);
        tick(3);
        chk(irq, 1'b0);
        tick(int'(STABLE) + 5);
        rd_reg(4'h4, d);
        chk(d, 32'h0);
        chk(display_code, 16'h4141);
    endtask
    task automatic t_oc_escalate;
        logic [31:0] d;
        int n;
        panel.press();
        for (int i = 1; i <= 9; i++)
        begin
            pulse(1'b0);
            n = 0;
            wait_on(n);
            off_chk(n, i == 9 ? LONG : SHORT);
        end
        rd_reg(4'h4, d);
        chk(d[3:0], 4'h0);
        rd_reg(4'h2, d);
        chk(d[2], 1'b1);
        wr_reg(4'h2, 32'hf);
        tick(int'(STABLE) + 5);
    endtask
    task automatic t_reg_short;
        logic [31:0] d;
        int n;
        for (int i = 1; i <= 2; i++)
        begin
            pulse(1'b1);
            chk(display_code, 16'h4132);
            chk({lock_led, voltage_led}, 2'b11);
            n = 0;
            wait_on(n);
            off_chk(n, i == 2 ? LONG : SHORT);
        end
        rd_reg(4'h4, d);
        chk(d[7:4], 4'h0);
        tick(int'(STABLE) + 5);
    endtask
    // Link failure alone must stop the amplifier; standby comes later.
    task automatic t_link_fwd;
        int n = 0;
        @(posedge clk) link_fail <= 1'b1;
        tick(2);
        chk(amp_enable, 1'b0);
        chk(display_code, 16'h4130);
        panel.stand(1'b1);
        @(posedge clk) link_fail <= 1'b0;
        tick(2);
        chk(display_code, 16'h4139);
        panel.turn(3'h0);
        tick(2);
        chk(display_code, 16'h2053);
        panel.stand(1'b0);
        wait_on(n);
        tick(2);
        chk(display_code, 16'h2050);
        panel.turn(3'h3);
    endtask
    // Retry barred locks the unit; a fatal mark makes the button useless.
    task automatic t_lock;
        logic [31:0] d;
        int n = 0;
        wr_reg(4'h0, 32'h3);
        pulse(1'b0);
        tick(int'(SHORT) + 10);
        chk(amp_enable, 1'b0);
        panel.press();
        tick(2);
        rd_reg(4'h1, d);
        chk(d[2:0], 3'h3);
        wr_reg(4'h0, 32'h0);
        panel.press();
        wait_on(n);
        chk(amp_enable, 1'b1);
        rd_reg(4'h4, d);
        chk(d, 32'h0);
        chk(current_led, 1'b0);
    endtask
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic end_of_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_oc_single();
        t_oc_escalate();
        t_reg_short();
        t_link_fwd();
        t_lock();
        end_of_test();
    end
    // The scenarios need about 1000 cycles; 5000 means a hang.
    initial
    begin
        #20000;
        error_cnt++;
        end_of_test();
    end
endmodule
